/* File: uccs_pkg.sv */
`default_nettype none
package uccs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_COMMAND  = 8'h08;
  localparam logic [7:0] OFS_DATA     = 8'h0C;
  localparam logic [7:0] OFS_AUX      = 8'h10;
  localparam logic [7:0] OFS_IFLAGS   = 8'h14;
  localparam logic [7:0] OFS_IENABLE  = 8'h18;
  localparam logic [7:0] OFS_CT_HIGH  = 8'h1C;
  localparam logic [7:0] OFS_CT_LOW   = 8'h20;
  localparam logic [7:0] OFS_PINS     = 8'h24;
  localparam logic [7:0] OFS_OUTPINS  = 8'h28;
  // command codes in the upper nibble
  localparam logic [3:0] CMD_PTR_ONE  = 4'h1;
  localparam logic [3:0] CMD_RX_RESET = 4'h2;
  localparam logic [3:0] CMD_TX_RESET = 4'h3;
  localparam logic [3:0] CMD_ERR_RST  = 4'h4;
  localparam logic [3:0] CMD_PTR_ZERO = 4'hB;
  // command low bit positions
  localparam int CMD_TX_OFF = 3;
  localparam int CMD_TX_ON  = 2;
  localparam int CMD_RX_OFF = 1;
  localparam int CMD_RX_ON  = 0;
  // mode and aux field positions
  localparam int M0_WDOG  = 7;
  localparam int M0_RXINT = 6;
  localparam int M1_RTS   = 7;
  localparam int M1_RXINT = 6;
  localparam int M1_BLOCK = 5;
  localparam int M1_PTYPE = 2;
  localparam int AUX_BAUD = 7;
  // parity modes
  localparam logic [1:0] PAR_WITH  = 2'b00;
  localparam logic [1:0] PAR_FORCE = 2'b01;
  localparam logic [1:0] PAR_WAKE  = 2'b11;
  // reset values, mode pointer limit and mode zero low read value
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [1:0] PTR_RST   = 2'd1;
  localparam logic [1:0] PTR_LAST  = 2'd2;
  localparam logic [3:0] M0_LOW_RD = 4'hF;
  // fifo fill thresholds
  localparam logic [3:0] FILL_ONE   = 4'd1;
  localparam logic [3:0] FILL_THREE = 4'd3;
  localparam logic [3:0] FILL_SIX   = 4'd6;
  localparam logic [3:0] FILL_EIGHT = 4'd8;
  // timing counts in 16x ticks
  localparam logic [3:0] OS_MID  = 4'd7;
  localparam logic [3:0] OS_LAST = 4'd15;
  localparam logic [9:0] WDOG_TICKS = 10'd640;
  // serial state codes, gray from idle through start, data and parity to stop
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000, SER_START = 3'b001, SER_DATA = 3'b011,
    SER_PAR  = 3'b010, SER_STOP  = 3'b110
  } uccs_ser_e;
  // one receive fifo entry
  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } uccs_rx_entry_s;
endpackage : uccs_pkg
`default_nettype wire

/* File: uccs_channel.sv */
// Register access over AHB-Lite and the register offsets were decided locally.
`default_nettype none
module uccs_channel #(
  parameter int          DEPTH    = 8,
  parameter logic [15:0] SET2_DIV = 16'd12
) (
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic [31:0] hrdata,
  output var   logic        hreadyout,
  output var   logic        hresp,
  input  wire  logic        rxd,
  input  wire  logic [7:0]  modem_pins,
  output var   logic        txd,
  output var   logic        request_to_send_out,
  output var   logic        irq_out
);
  import uccs_pkg::*;

  logic [7:0]  wr_addr;          // data-phase write address
  logic        wr_pend;          // write data phase active
  logic [7:0]  rd_addr;          // pending read address
  logic        rd_pend;          // read wait state active
  logic [7:0]  wdat;             // write byte
  logic        wr_cmd;           // command write strobe
  logic        wr_mode;          // mode write strobe
  logic        rd_mode;          // mode read strobe
  logic        rd_data;          // receive data pop strobe
  logic [3:0]  cmd_hi;           // upper command nibble
  logic [3:0]  mode_zero;        // stored upper nibble
  logic [7:0]  mode_one;         // character format
  logic [7:0]  mode_two;         // stored only
  logic [1:0]  mr_ptr;           // mode pointer
  logic [7:0]  auxiliary_control;
  logic [7:0]  interrupt_enables;
  logic [7:0]  timer_preset_high;
  logic [7:0]  timer_preset_low;
  logic        output_pin_rts;   // manual request-to-send level
  logic        tx_en;            // transmitter enabled
  logic        rx_en;            // receiver enabled
  logic [2:0]  err_hold;         // break, framing, parity shown
  logic        overrun;          // sticky overrun
  logic [7:0]  pin_s1;           // synchroniser stage one
  logic [7:0]  pin_s2;           // synchroniser stage two
  logic [7:0]  pin_s3;           // synchroniser stage three
  logic [7:0]  pin_levels;       // filtered pin levels
  logic [2:0]  rx_sync;          // rxd synchroniser
  logic        rx_s;             // filtered rxd
  logic [15:0] ct;               // counter/timer
  logic [15:0] ct_preset;        // full preset
  logic        tick;             // 16x baud tick
  logic        port_chg;         // sticky pin change flag
  logic        cnt_rdy;          // sticky counter flag
  logic        dbrk;             // sticky break flag
  uccs_rx_entry_s rx_mem [DEPTH];
  logic [7:0]  tx_mem [DEPTH];
  logic [2:0]  rx_wp, rx_rp, tx_wp, tx_rp;
  logic [3:0]  rx_cnt, tx_cnt;   // fill counts
  uccs_rx_entry_s rx_new;        // entry to push
  logic        rx_push;          // push pulse
  logic        rx_start_ok;      // valid start bit pulse
  logic        tx_pop;           // transmit fifo pop pulse
  uccs_ser_e   rx_st, tx_st;     // serial states
  logic [3:0]  rx_os, tx_os;     // oversample counters
  logic [2:0]  rx_bit, tx_bit;   // bit index
  logic [7:0]  rx_sh, tx_sh;     // shift registers
  logic        rx_par;           // received parity bit
  logic        tx_parity;        // parity to send
  logic        rts_neg;          // flow-control negation
  logic [9:0]  wd_cnt;           // watchdog tick count
  logic        wd_fire;          // watchdog expired
  logic        rx_bid;           // receive interrupt bid
  logic [7:0]  interrupt_flags;  // composed flag view
  logic [7:0]  status;           // composed status view
  logic        par_on;           // parity bit present
  logic [2:0]  last_bit;         // index of last data bit
  logic        exp_par;          // expected parity
  logic        rx_full, tx_full;
  logic        wr_iflags;        // flag clear strobe

  // bus strobes and field decode
  assign wdat      = hwdata[7:0];
  assign wr_cmd    = wr_pend && (wr_addr == OFS_COMMAND);
  assign wr_mode   = wr_pend && (wr_addr == OFS_MODE);
  assign wr_iflags = wr_pend && (wr_addr == OFS_IFLAGS);
  assign rd_mode   = rd_pend && (rd_addr == OFS_MODE);
  assign rd_data   = rd_pend && (rd_addr == OFS_DATA) && (rx_cnt != 4'd0);
  assign cmd_hi    = wdat[7:4];
  assign ct_preset = {timer_preset_high, timer_preset_low};
  assign rx_full   = (rx_cnt == FILL_EIGHT);
  assign tx_full   = (tx_cnt == FILL_EIGHT);
  assign par_on    = (mode_one[4:3] == PAR_WITH) || (mode_one[4:3] == PAR_FORCE)
                     || (mode_one[4:3] == PAR_WAKE);
  assign last_bit  = {1'b1, mode_one[1:0]};

  // parity expected on receive and sent on transmit
  always_comb begin
    exp_par = mode_one[M1_PTYPE];
    if (mode_one[4:3] == PAR_WITH) begin
      exp_par = (^rx_sh) ^ mode_one[M1_PTYPE];
    end
    tx_parity = mode_one[M1_PTYPE];
    if (mode_one[4:3] == PAR_WITH) begin
      tx_parity = (^tx_sh) ^ mode_one[M1_PTYPE];
    end
  end

  // receive interrupt bid from fill code
  always_comb begin
    unique case ({mode_zero[M0_RXINT - 4], mode_one[M1_RXINT]})
      2'b00:   rx_bid = (rx_cnt >= FILL_ONE);
      2'b01:   rx_bid = (rx_cnt >= FILL_THREE);
      2'b10:   rx_bid = (rx_cnt >= FILL_SIX);
      2'b11:   rx_bid = (rx_cnt == FILL_EIGHT);
    endcase
    if (wd_fire) begin
      rx_bid = 1'b1;
    end
  end

  // composed views
  assign interrupt_flags = {port_chg, 3'b000, cnt_rdy, dbrk, rx_bid,
                            tx_en && !tx_full};
  assign status = {err_hold, overrun, tx_cnt == 4'd0 && tx_st == SER_IDLE,
                   tx_en && !tx_full, rx_full, rx_cnt != 4'd0};

  // ahb address phase capture and read wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      rd_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      hreadyout <= 1'b1;
      if (hsel && htrans[1] && hready) begin
        // reads stall one cycle so side effects follow prior writes
        wr_pend   <= hwrite;
        rd_pend   <= !hwrite;
        hreadyout <= hwrite;
        wr_addr   <= haddr[7:0];
        rd_addr   <= haddr[7:0];
      end
    end
  end

  // read data mux, registered at the end of the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend) begin
      hrdata <= 32'h0000_0000;
      unique case (rd_addr)
        OFS_MODE: begin
          unique case (mr_ptr)
            2'd0:    hrdata[7:0] <= {mode_zero, M0_LOW_RD};
            2'd1:    hrdata[7:0] <= mode_one;
            default: hrdata[7:0] <= mode_two;
          endcase
        end
        OFS_STATUS:  hrdata[7:0] <= status;
        OFS_DATA:    hrdata[7:0] <= rx_mem[rx_rp].data;
        OFS_AUX:     hrdata[7:0] <= auxiliary_control;
        OFS_IFLAGS:  hrdata[7:0] <= interrupt_flags;
        OFS_IENABLE: hrdata[7:0] <= interrupt_enables;
        OFS_CT_HIGH: hrdata[7:0] <= timer_preset_high;
        OFS_CT_LOW:  hrdata[7:0] <= timer_preset_low;
        OFS_PINS:    hrdata[7:0] <= pin_levels;
        OFS_OUTPINS: hrdata[7:0] <= {7'h00, output_pin_rts};
        default:     hrdata[7:0] <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  // plain read/write registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auxiliary_control <= 8'h00;
      interrupt_enables <= 8'h00;
      timer_preset_high <= 8'h00;
      timer_preset_low  <= 8'h00;
      output_pin_rts    <= 1'b1;
    end else if (wr_pend) begin
      if (wr_addr == OFS_AUX) auxiliary_control <= wdat;
      if (wr_addr == OFS_IENABLE) interrupt_enables <= wdat;
      if (wr_addr == OFS_CT_HIGH) timer_preset_high <= wdat;
      if (wr_addr == OFS_CT_LOW) timer_preset_low <= wdat;
      if (wr_addr == OFS_OUTPINS) output_pin_rts <= wdat[0];
    end
  end

  // mode registers and their pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_zero <= MODE_RST[7:4];
      mode_one  <= MODE_RST;
      mode_two  <= MODE_RST;
      mr_ptr    <= PTR_RST;
    end else if (wr_cmd && cmd_hi == CMD_PTR_ZERO) begin
      mr_ptr <= 2'd0;
    end else if (wr_cmd && cmd_hi == CMD_PTR_ONE) begin
      mr_ptr <= PTR_RST;
    end else if (wr_mode || rd_mode) begin
      if (mr_ptr != PTR_LAST) begin
        mr_ptr <= mr_ptr + 2'd1;
      end
      if (wr_mode) begin
        unique case (mr_ptr)
          2'd0:    mode_zero <= wdat[7:4];
          2'd1:    mode_one  <= wdat;
          default: mode_two  <= wdat;
        endcase
      end
    end
  end

  // enables from command low bits and resets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_en <= 1'b0;
      rx_en <= 1'b0;
    end else if (wr_cmd) begin
      if (wdat[CMD_TX_ON]) tx_en <= 1'b1;
      if (wdat[CMD_TX_OFF] || cmd_hi == CMD_TX_RESET) tx_en <= 1'b0;
      if (wdat[CMD_RX_ON]) rx_en <= 1'b1;
      if (wdat[CMD_RX_OFF] || cmd_hi == CMD_RX_RESET) rx_en <= 1'b0;
    end
  end

  // pin and rxd synchronisers with agreement filter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1     <= 8'h00;
      pin_s2     <= 8'h00;
      pin_s3     <= 8'h00;
      pin_levels <= 8'h00;
      rx_sync    <= 3'b111;
      rx_s       <= 1'b1;
    end else begin
      pin_s1  <= modem_pins;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      rx_sync <= {rx_sync[1:0], rxd};
      for (int i = 0; i < 8; i++) begin
        if (pin_s2[i] == pin_s3[i]) pin_levels[i] <= pin_s3[i];
      end
      if (rx_sync[1] == rx_sync[2]) rx_s <= rx_sync[2];
    end
  end

  // counter/timer and baud tick; aux top bit picks the source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ct   <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (ct == 16'h0000);
      if (ct == 16'h0000) begin
        ct <= auxiliary_control[AUX_BAUD] ? SET2_DIV : ct_preset;
      end else begin
        ct <= ct - 16'h0001;
      end
    end
  end

  // sticky interrupt sources, set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_chg <= 1'b0;
      cnt_rdy  <= 1'b0;
      dbrk     <= 1'b0;
    end else begin
      if (wr_iflags && wdat[7]) port_chg <= 1'b0;
      if (wr_iflags && wdat[3]) cnt_rdy <= 1'b0;
      if (wr_iflags && wdat[2]) dbrk <= 1'b0;
      if (|(auxiliary_control[3:0] & (pin_s3[3:0] ^ pin_levels[3:0])
            & ~(pin_s2[3:0] ^ pin_s3[3:0]))) port_chg <= 1'b1;
      if (ct == 16'h0000) cnt_rdy <= 1'b1;
      if (rx_push && rx_new.brk) dbrk <= 1'b1;
    end
  end

  // interrupt request from enabled flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(interrupt_flags & interrupt_enables);
    end
  end

  // receive fifo with flags stored per character
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp  <= 3'd0;
      rx_rp  <= 3'd0;
      rx_cnt <= 4'd0;
    end else if (wr_cmd && cmd_hi == CMD_RX_RESET) begin
      rx_wp  <= 3'd0;
      rx_rp  <= 3'd0;
      rx_cnt <= 4'd0;
    end else begin
      if (rx_push && !rx_full) begin
        rx_mem[rx_wp] <= rx_new;
        rx_wp <= rx_wp + 3'd1;
      end
      if (rd_data) rx_rp <= rx_rp + 3'd1;
      rx_cnt <= rx_cnt + {3'b000, rx_push && !rx_full} - {3'b000, rd_data};
    end
  end

  // error status shown in the status register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_hold <= 3'b000;
      overrun  <= 1'b0;
    end else begin
      if (wr_cmd && (cmd_hi == CMD_ERR_RST || cmd_hi == CMD_RX_RESET)) begin
        err_hold <= 3'b000;
        overrun  <= 1'b0;
      end else if (!mode_one[M1_BLOCK] && rx_cnt != 4'd0) begin
        err_hold <= {rx_mem[rx_rp].brk, rx_mem[rx_rp].fe, rx_mem[rx_rp].pe};
      end
      if (mode_one[M1_BLOCK] && rx_push) begin
        err_hold <= err_hold | {rx_new.brk, rx_new.fe, rx_new.pe};
      end
      if (rx_push && rx_full) overrun <= 1'b1;
    end
  end

  // receiver framing state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st       <= SER_IDLE;
      rx_os       <= 4'd0;
      rx_bit      <= 3'd0;
      rx_sh       <= 8'h00;
      rx_par      <= 1'b0;
      rx_push     <= 1'b0;
      rx_start_ok <= 1'b0;
      rx_new      <= '0;
    end else begin
      rx_push     <= 1'b0;
      rx_start_ok <= 1'b0;
      if (!rx_en) begin
        rx_st <= SER_IDLE;
      end else if (tick) begin
        rx_os <= rx_os + 4'd1;
        unique case (rx_st)
          SER_IDLE: begin
            rx_os <= 4'd0;
            if (!rx_s) rx_st <= SER_START;
          end
          SER_START: begin
            if (rx_os == OS_MID) begin
              rx_os  <= 4'd0;
              rx_bit <= 3'd0;
              rx_sh  <= 8'h00;
              rx_par <= 1'b0;
              rx_st  <= rx_s ? SER_IDLE : SER_DATA; // false start back to idle
              rx_start_ok <= !rx_s;
            end
          end
          SER_DATA: begin
            if (rx_os == OS_LAST) begin
              rx_sh[rx_bit] <= rx_s;
              rx_bit <= rx_bit + 3'd1;
              if (rx_bit == last_bit) rx_st <= par_on ? SER_PAR : SER_STOP;
            end
          end
          SER_PAR: begin
            if (rx_os == OS_LAST) begin
              rx_par <= rx_s;
              rx_st  <= SER_STOP;
            end
          end
          SER_STOP: begin
            if (rx_os == OS_LAST) begin
              rx_st       <= SER_IDLE;
              rx_push     <= 1'b1;
              rx_new.data <= rx_sh;
              rx_new.fe   <= !rx_s;
              rx_new.brk  <= !rx_s && rx_sh == 8'h00 && !rx_par;
              rx_new.pe   <= par_on && mode_one[4:3] != PAR_WAKE
                             && rx_par != exp_par;
            end
          end
          default: rx_st <= SER_IDLE;
        endcase
      end
    end
  end

  // request-to-send flow control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_neg             <= 1'b0;
      request_to_send_out <= 1'b1;
    end else begin
      if (!rx_full) rts_neg <= 1'b0;
      if (rx_start_ok && rx_full && mode_one[M1_RTS]) rts_neg <= 1'b1;
      request_to_send_out <= output_pin_rts || rts_neg;
    end
  end

  // receive watchdog counts idle ticks while data waits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt  <= 10'd0;
      wd_fire <= 1'b0;
    end else if (!mode_zero[M0_WDOG - 4] || rx_cnt == 4'd0 || rx_push || rd_data) begin
      wd_cnt  <= 10'd0;
      wd_fire <= 1'b0;
    end else if (tick) begin
      if (wd_cnt == WDOG_TICKS) wd_fire <= 1'b1;
      else wd_cnt <= wd_cnt + 10'd1;
    end
  end

  // transmit fifo, loads ignored while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_wp  <= 3'd0;
      tx_rp  <= 3'd0;
      tx_cnt <= 4'd0;
    end else if (wr_cmd && cmd_hi == CMD_TX_RESET) begin
      tx_wp  <= 3'd0;
      tx_rp  <= 3'd0;
      tx_cnt <= 4'd0;
    end else begin
      if (wr_pend && wr_addr == OFS_DATA && tx_en && !tx_full) begin
        tx_mem[tx_wp] <= wdat;
        tx_wp <= tx_wp + 3'd1;
      end
      if (tx_pop) tx_rp <= tx_rp + 3'd1;
      tx_cnt <= tx_cnt + {3'b000, wr_pend && wr_addr == OFS_DATA && tx_en && !tx_full}
                - {3'b000, tx_pop};
    end
  end

  // transmitter framing state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st  <= SER_IDLE;
      tx_os  <= 4'd0;
      tx_bit <= 3'd0;
      tx_sh  <= 8'h00;
      tx_pop <= 1'b0;
      txd    <= 1'b1;
    end else begin
      tx_pop <= 1'b0;
      if (tick) begin
        tx_os <= tx_os + 4'd1;
        unique case (tx_st)
          SER_IDLE: begin
            txd   <= 1'b1;
            tx_os <= 4'd0;
            if (tx_en && tx_cnt != 4'd0 && !tx_pop) begin
              tx_sh  <= tx_mem[tx_rp] & ~(8'hFF << (4'd1 + {1'b0, last_bit}));
              tx_pop <= 1'b1;
              tx_st  <= SER_START;
              txd    <= 1'b0;
            end
          end
          SER_START: begin
            if (tx_os == OS_LAST) begin
              tx_st  <= SER_DATA;
              tx_bit <= 3'd0;
              txd    <= tx_sh[0];
            end
          end
          SER_DATA: begin
            if (tx_os == OS_LAST) begin
              tx_bit <= tx_bit + 3'd1;
              txd    <= tx_sh[tx_bit + 3'd1];
              if (tx_bit == last_bit) begin
                tx_st <= par_on ? SER_PAR : SER_STOP;
                txd   <= par_on ? tx_parity : 1'b1;
              end
            end
          end
          SER_PAR: begin
            if (tx_os == OS_LAST) begin
              tx_st <= SER_STOP;
              txd   <= 1'b1;
            end
          end
          SER_STOP: begin
            if (tx_os == OS_LAST) tx_st <= SER_IDLE;
          end
          default: tx_st <= SER_IDLE;
        endcase
      end
    end
  end
endmodule : uccs_channel
`default_nettype wire

/* File: uccs_chk.sv */
`default_nettype none
module uccs_chk
  import uccs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  modem_pins
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // transfer taken at this edge
  wire logic take = hsel && htrans[1] && hready;
  // one wait cycle then data
  sequence rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  okay_resp_a: assert property (!hresp) else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> rd_ans) else $error("read wait wrong");
  write_go_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  wait_cause_a: assert property (!hreadyout |-> $past(take && !hwrite)) else $error("stray wait");
  wait_once_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata)) else $error("data moved");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper data set");
  pins_read_a: assert property (take && !hwrite && haddr[7:0] == OFS_PINS
    |=> ##1 hrdata[7:0] == $past(modem_pins, 5)) else $error("pin levels wrong");
endmodule : uccs_chk
bind uccs_channel uccs_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .modem_pins(modem_pins));
`default_nettype wire

/* File: uccs_remote.sv */
`default_nettype none
module uccs_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic hclk,
  output var logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1; // line idles marking
  // start, eight data lsb first, stop level as given
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge hclk);
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge hclk);
  endtask : send
endmodule : uccs_remote
`default_nettype wire

/* File: uart_channel_control_status_test.sv */
`default_nettype none
module uart_channel_control_status_test;
  timeunit 1ns;
  timeprecision 1ns;
  import uccs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, rxd, txd, irq, rts;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  rd;
  logic [7:0]  pins;             // modem pin levels driven at the far side
  int          miscompares = 0, n_tests = 0;
  uccs_channel #(.DEPTH(8), .SET2_DIV(16'd12)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .rxd(rxd), .modem_pins(pins), .txd(txd), .request_to_send_out(rts), .irq_out(irq));
  uccs_remote #(.BIT_CLKS(32)) i_rem (.hclk(hclk), .rxd(rxd));
  // free running bus clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // one single ahb transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : xfer
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // masked register read compare
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    cmp(rd & m, e);
  endtask : rdc
  // command write with spacing
  task automatic cmd(input logic [7:0] c);
    xfer(1'b1, OFS_COMMAND, c);
    repeat (3) @(posedge hclk);
  endtask : cmd
  task automatic results;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // hang guard
  initial begin
    #800000;
    miscompares++;
    results();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    pins = 8'hA5;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    cmd(8'hB0);
    xfer(1'b1, OFS_MODE, 8'h40);
    xfer(1'b1, OFS_MODE, 8'h33);
    xfer(1'b1, OFS_MODE, 8'h55);
    cmd(8'hB0);
    rdc(OFS_MODE, 8'hFF, 8'h4F);
    rdc(OFS_MODE, 8'hFF, 8'h33);
    rdc(OFS_MODE, 8'hFF, 8'h55);
    rdc(OFS_MODE, 8'hFF, 8'h55);
    xfer(1'b1, OFS_CT_HIGH, 8'h00);
    xfer(1'b1, OFS_CT_LOW, 8'h01);
    rdc(OFS_CT_LOW, 8'hFF, 8'h01);
    rdc(OFS_PINS, 8'hFF, 8'hA5);
    // pin change flag only for pins enabled in aux low bits
    rdc(OFS_IFLAGS, 8'h80, 8'h00);
    xfer(1'b1, OFS_AUX, 8'h01);
    pins <= 8'hA4;
    repeat (6) @(posedge hclk);
    rdc(OFS_IFLAGS, 8'h80, 8'h80);
    rdc(OFS_PINS, 8'hFF, 8'hA4);
    cmd(8'h04);
    rdc(OFS_IFLAGS, 8'h01, 8'h01);
    cmd(8'h08);
    rdc(OFS_IFLAGS, 8'h01, 8'h00);
    xfer(1'b1, OFS_DATA, 8'h00);
    cmd(8'h04);
    repeat (40) @(posedge hclk);
    cmp({7'h0, txd}, 8'h01);
    cmd(8'h01);
    for (int i = 0; i < 5; i++) i_rem.send(8'(8'h11 * i), 1'b1);
    rdc(OFS_IFLAGS, 8'h02, 8'h00);
    i_rem.send(8'h5A, 1'b1);
    rdc(OFS_IFLAGS, 8'h02, 8'h02);
    cmp({7'h0, irq}, 8'h00);
    xfer(1'b1, OFS_IENABLE, 8'h02);
    repeat (3) @(posedge hclk);
    cmp({7'h0, irq}, 8'h01);
    i_rem.send(8'h00, 1'b0);
    rdc(OFS_STATUS, 8'h81, 8'h81);
    rdc(OFS_DATA, 8'hFF, 8'h00);
    for (int i = 0; i < 6; i++) xfer(1'b0, OFS_DATA, 8'h00);
    rdc(OFS_STATUS, 8'h81, 8'h80);
    cmd(8'h40);
    rdc(OFS_STATUS, 8'h80, 8'h00);
    // manual request-to-send driven low, then automatic flow control
    xfer(1'b1, OFS_OUTPINS, 8'h00);
    cmd(8'h10);
    xfer(1'b1, OFS_MODE, 8'hB3);
    i_rem.send(8'h3C, 1'b1);
    cmd(8'hB0);
    xfer(1'b1, OFS_MODE, 8'hC0);
    rdc(OFS_IFLAGS, 8'h02, 8'h00);
    repeat (1400) @(posedge hclk);
    rdc(OFS_IFLAGS, 8'h02, 8'h02);
    cmp({7'h0, rts}, 8'h00);
    for (int i = 0; i < 8; i++) i_rem.send(8'(i), 1'b1);
    cmp({7'h0, rts}, 8'h01);
    rdc(OFS_STATUS, 8'h12, 8'h12);
    rdc(OFS_DATA, 8'hFF, 8'h3C);
    repeat (2) @(posedge hclk);
    cmp({7'h0, rts}, 8'h00);
    results();
  end
endmodule : uart_channel_control_status_test
`default_nettype wire
